// File: pkg/ttc_pkg.sv
package ttc_pkg;

   // register indices; byte address is four times the index
   localparam logic [7:0]  IDX_CTRL      = 8'hc8;
   localparam logic [7:0]  IDX_RCAP_LO   = 8'hca;
   localparam logic [7:0]  IDX_RCAP_HI   = 8'hcb;
   localparam logic [7:0]  IDX_CNT_LO    = 8'hcc;
   localparam logic [7:0]  IDX_CNT_HI    = 8'hcd;
   localparam logic [7:0]  IDX_CLK_SPEED = 8'h8e;
   localparam logic [7:0]  IDX_INT_STAT  = 8'he0;
   localparam logic [7:0]  IDX_INT_MASK  = 8'he1;
   localparam int unsigned ADDR_W        = 12;
   localparam int unsigned IDX_LSB       = 2;

   // field positions
   localparam int unsigned FAST_TICK_BIT = 5;
   localparam int unsigned INT_OVF_BIT   = 0;
   localparam int unsigned INT_EXT_BIT   = 1;
   localparam int unsigned OVF_FLAG_BIT  = 7;
   localparam int unsigned EXT_FLAG_BIT  = 6;

   // reset values and constants
   localparam logic [7:0]  RST_BYTE      = 8'h00;
   localparam logic [1:0]  RST_INT       = 2'h0;
   localparam logic [15:0] CNT_MAX       = 16'hffff;
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;

   // clocks per count tick
   localparam logic [3:0]  DIV_BAUD      = 4'h2;
   localparam logic [3:0]  DIV_FAST      = 4'h4;
   localparam logic [3:0]  DIV_SLOW      = 4'hc;

   typedef struct packed {
      logic overflow_flag;
      logic external_edge_flag;
      logic rx_baud_source_select;
      logic tx_baud_source_select;
      logic ext_trigger_enable;
      logic run_control;
      logic count_source_select;
      logic capture_reload_select;
   } ttc_ctrl_s;

   typedef struct packed {
      logic rx_tick;
      logic tx_tick;
   } ttc_baud_s;

endpackage : ttc_pkg

// File: src/ttc_timer.sv
// Summary of operation
// R1: overflow from ffff sets sticky overflow flag
// R2: overflow flag set only when not baud
// R3: software writing overflow flag raises request
// R4: trigger falling edge sets external flag
// R5: software setting external flag raises request
// R6: rx select picks receiver baud tick source
// R7: tx select picks transmitter baud tick source
// R8: baud mode ticks every two clocks
// R9: trigger enable gates capture/reload outside baud
// R10: run bit starts, halt keeps count
// R11: count source: prescaled clock or pin edges
// R12: reload on overflow and trigger edge
// R13: capture count on trigger edge
// R14: baud mode forces auto-reload on overflow
// R15: low capture byte captures and reloads low
// R16: high capture byte captures and reloads high
// R17: count bytes readable, reset to zero
// R18: one request while either flag set
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module ttc_timer (
   // clock and reset
   input  wire logic                      aclk,
   input  wire logic                      aresetn,
   // axi4-lite write address
   input  wire logic [ttc_pkg::ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                      s_axi_awvalid,
   output logic                           s_axi_awready,
   // axi4-lite write data and response
   input  wire logic [31:0]               s_axi_wdata,
   input  wire logic [3:0]                s_axi_wstrb,
   input  wire logic                      s_axi_wvalid,
   output logic                           s_axi_wready,
   output logic [1:0]                     s_axi_bresp,
   output logic                           s_axi_bvalid,
   input  wire logic                      s_axi_bready,
   // axi4-lite read
   input  wire logic [ttc_pkg::ADDR_W-1:0] s_axi_araddr,
   input  wire logic                      s_axi_arvalid,
   output logic                           s_axi_arready,
   output logic [31:0]                    s_axi_rdata,
   output logic [1:0]                     s_axi_rresp,
   output logic                           s_axi_rvalid,
   input  wire logic                      s_axi_rready,
   // pins
   input  wire logic                      ext_trigger_pin,
   input  wire logic                      event_count_pin,
   // baud logic of serial port 0
   input  wire logic                      other_timer_overflow,
   output ttc_pkg::ttc_baud_s             baud_tick,
   // interrupts
   output logic                           timer_irq,
   output logic                           irq
);
   import ttc_pkg::*;

   ttc_ctrl_s   ctrl;
   logic [7:0]  rcap_lo, rcap_hi, cnt_lo, cnt_hi, clk_speed;
   logic [1:0]  int_stat, int_mask;
   logic [15:0] count, rcap;
   assign count = {cnt_hi, cnt_lo};
   assign rcap  = {rcap_hi, rcap_lo};

   // ---------------- axi4-lite slave ----------------
   logic                aw_hold, w_hold, do_write;
   logic [ADDR_W-1:0]   aw_addr, ar_addr;
   logic [31:0]         w_data;
   logic [3:0]          w_strb;
   logic [7:0]          w_idx, r_idx;
   logic                w_ok, r_ok, wr_lane;

   // address and data are taken in either order, then held until the write
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold       <= 1'b0;
         s_axi_awready <= 1'b0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_hold       <= 1'b1;
         aw_addr       <= s_axi_awaddr;
         s_axi_awready <= 1'b0;
      end else begin
         if (do_write) aw_hold <= 1'b0;
         s_axi_awready <= !aw_hold && !s_axi_bvalid;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_hold       <= 1'b0;
         s_axi_wready <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_hold       <= 1'b1;
         w_data       <= s_axi_wdata;
         w_strb       <= s_axi_wstrb;
         s_axi_wready <= 1'b0;
      end else begin
         if (do_write) w_hold <= 1'b0;
         s_axi_wready <= !w_hold && !s_axi_bvalid;
      end
   end

   assign do_write = aw_hold && w_hold && !s_axi_bvalid;
   assign w_idx    = aw_addr[IDX_LSB +: 8];
   assign w_ok     = (aw_addr[ADDR_W-1:IDX_LSB+8] == '0) && (aw_addr[IDX_LSB-1:0] == '0) &&
                     (w_idx inside {IDX_CTRL, IDX_RCAP_LO, IDX_RCAP_HI, IDX_CNT_LO,
                                    IDX_CNT_HI, IDX_CLK_SPEED, IDX_INT_STAT, IDX_INT_MASK});
   // only byte lane 0 carries register data; other lanes are ignored
   assign wr_lane  = do_write && w_ok && w_strb[0];

   // write response one cycle after both halves are in
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= w_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   assign r_idx = s_axi_araddr[IDX_LSB +: 8];
   assign r_ok  = (s_axi_araddr[ADDR_W-1:IDX_LSB+8] == '0) && (s_axi_araddr[IDX_LSB-1:0] == '0);

   // read data is sampled at the address handshake and answered next cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rresp   <= RESP_OKAY;
         s_axi_rdata   <= '0;
         unique case (r_ok ? r_idx : 8'h00)
            IDX_CTRL:      s_axi_rdata[7:0] <= ctrl;
            IDX_RCAP_LO:   s_axi_rdata[7:0] <= rcap_lo;
            IDX_RCAP_HI:   s_axi_rdata[7:0] <= rcap_hi;
            IDX_CNT_LO:    s_axi_rdata[7:0] <= cnt_lo; // R17
            IDX_CNT_HI:    s_axi_rdata[7:0] <= cnt_hi; // R17
            IDX_CLK_SPEED: s_axi_rdata[7:0] <= clk_speed;
            IDX_INT_STAT:  s_axi_rdata[1:0] <= int_stat;
            IDX_INT_MASK:  s_axi_rdata[1:0] <= int_mask;
            default:       s_axi_rresp      <= RESP_SLVERR;
         endcase
      end else begin
         if (s_axi_rready) s_axi_rvalid <= 1'b0;
         // a new address is taken once the previous answer is gone or leaving
         s_axi_arready <= !s_axi_rvalid || s_axi_rready;
      end
   end

   // ---------------- pin synchronisers ----------------
   logic [2:0] trg_sync, evt_sync;
   logic       trg_lvl, evt_lvl, trg_fall, evt_fall;

   // three stages; a level counts once stages two and three agree
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         trg_sync <= 3'h7;
         evt_sync <= 3'h7;
         trg_lvl  <= 1'b1;
         evt_lvl  <= 1'b1;
      end else begin
         trg_sync <= {trg_sync[1:0], ext_trigger_pin};
         evt_sync <= {evt_sync[1:0], event_count_pin};
         if (trg_sync[1] == trg_sync[2]) trg_lvl <= trg_sync[2];
         if (evt_sync[1] == evt_sync[2]) evt_lvl <= evt_sync[2];
      end
   end

   assign trg_fall = trg_lvl && (trg_sync[1] == trg_sync[2]) && !trg_sync[2];
   assign evt_fall = evt_lvl && (evt_sync[1] == evt_sync[2]) && !evt_sync[2];

   // ---------------- count engine ----------------
   logic       baud, tick, ovf, ovf_flag_set, ext_flag_set, ext_act, reload, capture;
   logic [3:0] pre, pre_lim;
   logic       pre_tick;

   assign baud    = ctrl.rx_baud_source_select || ctrl.tx_baud_source_select; // R8
   assign pre_lim = baud ? DIV_BAUD : (clk_speed[FAST_TICK_BIT] ? DIV_FAST : DIV_SLOW);

   // prescaler; restarts whenever the timer is halted so the first tick is a full period
   always_ff @(posedge aclk) begin
      if (!aresetn || !ctrl.run_control) pre <= '0;
      else if (pre >= pre_lim - 4'h1)    pre <= '0;
      else                               pre <= pre + 4'h1;
   end

   assign pre_tick = ctrl.run_control && (pre >= pre_lim - 4'h1);
   // baud mode ignores the count source select
   assign tick     = baud ? pre_tick : // R8
                     (ctrl.count_source_select ? (ctrl.run_control && evt_fall) : pre_tick); // R11 R10
   assign ovf      = tick && (count == CNT_MAX); // R1
   assign ext_act  = ctrl.ext_trigger_enable && trg_fall && !baud; // R9
   assign reload   = (ovf && (baud || !ctrl.capture_reload_select)) || // R12 R14
                     (ext_act && !ctrl.capture_reload_select); // R12
   assign capture  = ext_act && ctrl.capture_reload_select; // R13
   assign ovf_flag_set = ovf && !baud; // R2
   assign ext_flag_set = ctrl.ext_trigger_enable && trg_fall; // R4

   // count bytes; a software write wins over the engine in that cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_lo <= RST_BYTE; // R17
         cnt_hi <= RST_BYTE; // R17
      end else if (wr_lane && (w_idx == IDX_CNT_LO || w_idx == IDX_CNT_HI)) begin
         if (w_idx == IDX_CNT_LO) cnt_lo <= w_data[7:0];
         else                     cnt_hi <= w_data[7:0];
      end else if (reload) begin
         {cnt_hi, cnt_lo} <= rcap; // R15 R16
      end else if (tick) begin
         {cnt_hi, cnt_lo} <= count + 16'h0001; // R10
      end
   end

   // capture/reload pair; capture beats a software write in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rcap_lo <= RST_BYTE;
         rcap_hi <= RST_BYTE;
      end else if (capture) begin
         rcap_lo <= cnt_lo; // R15
         rcap_hi <= cnt_hi; // R16
      end else if (wr_lane && w_idx == IDX_RCAP_LO) begin
         rcap_lo <= w_data[7:0];
      end else if (wr_lane && w_idx == IDX_RCAP_HI) begin
         rcap_hi <= w_data[7:0];
      end
   end

   // control register; hardware setting a flag wins over a software clear
   ttc_ctrl_s next_ctrl;
   always_comb begin
      next_ctrl = ctrl;
      if (wr_lane && w_idx == IDX_CTRL) next_ctrl = ttc_ctrl_s'(w_data[7:0]); // R3 R5
      if (ovf_flag_set) next_ctrl.overflow_flag      = 1'b1; // R1
      if (ext_flag_set) next_ctrl.external_edge_flag = 1'b1; // R4
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl      <= ttc_ctrl_s'(RST_BYTE);
         clk_speed <= RST_BYTE;
         timer_irq <= 1'b0;
      end else begin
         ctrl      <= next_ctrl;
         timer_irq <= next_ctrl.overflow_flag || next_ctrl.external_edge_flag; // R18 R3 R5
         if (wr_lane && w_idx == IDX_CLK_SPEED) clk_speed <= w_data[7:0];
      end
   end

   // ---------------- interrupt status and mask ----------------
   logic [1:0] next_stat, evt_bits;
   assign evt_bits = {ext_flag_set, ovf_flag_set};
   always_comb begin
      next_stat = int_stat;
      if (wr_lane && w_idx == IDX_INT_STAT) next_stat = int_stat & ~w_data[1:0];
      next_stat = next_stat | evt_bits; // set wins over write-one-to-clear
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         int_stat <= RST_INT;
         int_mask <= RST_INT;
         irq      <= 1'b0;
      end else begin
         int_stat <= next_stat;
         if (wr_lane && w_idx == IDX_INT_MASK) int_mask <= w_data[1:0];
         irq      <= |(next_stat & ((wr_lane && w_idx == IDX_INT_MASK) ? w_data[1:0] : int_mask));
      end
   end

   // ---------------- baud ticks for serial port 0 ----------------
   // registered, so the serial logic sees each tick one cycle after the overflow
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         baud_tick <= '0;
      end else begin
         baud_tick.rx_tick <= ctrl.rx_baud_source_select ? ovf : other_timer_overflow; // R6
         baud_tick.tx_tick <= ctrl.tx_baud_source_select ? ovf : other_timer_overflow; // R7
      end
   end

   // ---------------- assertions ----------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   logic ctrl_wr, cnt_wr;
   assign ctrl_wr = wr_lane && w_idx == IDX_CTRL;
   assign cnt_wr  = wr_lane && (w_idx == IDX_CNT_LO || w_idx == IDX_CNT_HI);

   property p_ovf_flag_set;
      ovf_flag_set |=> ctrl.overflow_flag;
   endproperty
   a_ovf_flag_set: assert property (p_ovf_flag_set) else $error("overflow flag not set"); // R1

   property p_ovf_only_timer;
      $rose(ctrl.overflow_flag) |-> !$past(baud) || $past(ctrl_wr);
   endproperty
   a_ovf_only_timer: assert property (p_ovf_only_timer) else $error("flag set in baud mode"); // R2

   property p_sw_irq;
      (ctrl_wr && w_data[OVF_FLAG_BIT]) |=> timer_irq && ctrl.overflow_flag;
   endproperty
   a_sw_irq: assert property (p_sw_irq) else $error("software flag write gave no request"); // R3

   property p_ext_flag;
      (ctrl.ext_trigger_enable && trg_fall) |=> ctrl.external_edge_flag;
   endproperty
   a_ext_flag: assert property (p_ext_flag) else $error("external flag missed"); // R4

   property p_baud_rate;
      (baud && tick) ##1 baud |-> !tick ##1 (tick || !baud || !ctrl.run_control);
   endproperty
   a_baud_rate: assert property (p_baud_rate) else $error("baud tick not every 2 clocks"); // R8

   property p_halt_hold;
      (!ctrl.run_control && !cnt_wr && !reload) |=> count == $past(count);
   endproperty
   a_halt_hold: assert property (p_halt_hold) else $error("count moved while halted"); // R10

   property p_capture;
      (capture && !cnt_wr) |=> rcap == $past(count);
   endproperty
   a_capture: assert property (p_capture) else $error("capture value wrong"); // R13

   property p_reload;
      (reload && !cnt_wr && !capture) |=> count == $past(rcap);
   endproperty
   a_reload: assert property (p_reload) else $error("reload value wrong"); // R12

   property p_req;
      timer_irq == (ctrl.overflow_flag || ctrl.external_edge_flag);
   endproperty
   a_req: assert property (p_req) else $error("request does not follow flags"); // R18

   property p_bvalid_hold;
      (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid;
   endproperty
   a_bvalid_hold: assert property (p_bvalid_hold) else $error("bvalid dropped early");

   c_ovf:     cover property (ovf_flag_set);
   c_capture: cover property (capture);
   c_baud:    cover property (baud && ovf);
   c_irq:     cover property ($rose(irq));

endmodule : ttc_timer

// File: tb/ttc_pin_model.sv
`timescale 1ns/1ns
// far side: pins idle high and fall on command, the other timer overflows on a fixed period
module ttc_pin_model #(
   parameter int OTHER_PER = 20
) (
   // clock and reset
   input  wire logic               aclk,
   input  wire logic               aresetn,
   // bench commands
   input  wire logic               trig_req,
   input  wire logic               evt_req,
   input  wire logic               clr_counts,
   // pins and baud logic
   output logic                    ext_trigger_pin,
   output logic                    event_count_pin,
   output logic                    other_timer_overflow,
   input  wire ttc_pkg::ttc_baud_s baud_tick,
   output logic [15:0]             rx_count,
   output logic [15:0]             tx_count
);
   import ttc_pkg::*;
   logic [2:0] trig_low;
   logic [2:0] evt_low;
   int         per_cnt;
   // pins stay low six clocks so the three-flop synchroniser cannot miss the fall
   // reset puts both pins at their idle high level
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         trig_low <= 3'h0;
         evt_low  <= 3'h0;
      end else begin
         if (trig_req) begin
            trig_low <= 3'h6;
         end else if (trig_low != 3'h0) begin
            trig_low <= trig_low - 3'h1;
         end
         if (evt_req) begin
            evt_low <= 3'h6;
         end else if (evt_low != 3'h0) begin
            evt_low <= evt_low - 3'h1;
         end
      end
   end
   assign ext_trigger_pin = (trig_low == 3'h0);
   assign event_count_pin = (evt_low == 3'h0);
   // other timer: one-cycle pulse, same clock
   always_ff @(posedge aclk) begin
      per_cnt <= (!aresetn || per_cnt == OTHER_PER - 1) ? 0 : per_cnt + 1;
      other_timer_overflow <= aresetn && (per_cnt == OTHER_PER - 1);
   end
   // serial port 0 sees one baud tick per pulse
   always_ff @(posedge aclk) begin
      if (!aresetn || clr_counts) begin
         rx_count <= 16'h0;
         tx_count <= 16'h0;
      end else begin
         rx_count <= rx_count + {15'h0, baud_tick.rx_tick};
         tx_count <= tx_count + {15'h0, baud_tick.tx_tick};
      end
   end
endmodule : ttc_pin_model

// File: tb/test_timer_two_capture_reload_baud.sv
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin fail_count++; \
   $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); end end
module test_timer_two_capture_reload_baud;
   import ttc_pkg::*;
   localparam int PER = 20;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [11:0] awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, rdata;
   logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic        awready, wready, bvalid, arready, rvalid, timer_irq, irq;
   logic [1:0]  bresp, rresp, rsp;
   logic        trig_req = 0, evt_req = 0, clr_counts = 0;
   logic [3:0]  wstrb = 4'hf;
   logic        trig_pin, evt_pin, other_ovf;
   ttc_baud_s   baud_tick;
   logic [15:0] rx_count, tx_count;
   logic [31:0] rd;
   logic [7:0]  hi, lo, hi2, lo2;
   logic [7:0]  regs [8] = '{IDX_CTRL, IDX_RCAP_LO, IDX_RCAP_HI, IDX_CNT_LO, IDX_CNT_HI,
                            IDX_CLK_SPEED, IDX_INT_STAT, IDX_INT_MASK};
   logic [7:0]  modes [3] = '{8'h35, 8'h26, 8'h14};
   int          checks_done = 0, fail_count = 0, seed = 65, i, n;
   // 125 MHz
   always #4 aclk = ~aclk;
   ttc_timer i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .ext_trigger_pin(trig_pin), .event_count_pin(evt_pin), .other_timer_overflow(other_ovf),
      .baud_tick(baud_tick), .timer_irq(timer_irq), .irq(irq));
   ttc_pin_model #(.OTHER_PER(PER)) i_pins (.aclk(aclk), .aresetn(aresetn),
      .trig_req(trig_req), .evt_req(evt_req), .clr_counts(clr_counts),
      .ext_trigger_pin(trig_pin), .event_count_pin(evt_pin), .other_timer_overflow(other_ovf),
      .baud_tick(baud_tick), .rx_count(rx_count), .tx_count(tx_count));
   task automatic wrap_up();
      if (fail_count == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : wrap_up
   // a bounded wait that runs out ends the run as a mismatch
   task automatic give_up(input int k, input int lim);
      if (k >= lim) begin
         fail_count++;
         wrap_up();
      end
   endtask : give_up
   task automatic wr(input logic [11:0] a, input logic [7:0] v);
      int k;
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h0, v};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (k = 0; k < 100; k++) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      rsp = bresp;
      bready <= 1'b0;
      give_up(k, 100);
   endtask : wr
   task automatic rdr(input logic [11:0] a);
      int k;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (k = 0; k < 100; k++) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      rd = rdata;
      rsp = rresp;
      rready <= 1'b0;
      give_up(k, 100);
   endtask : rdr
   function automatic logic [11:0] ad(input logic [7:0] idx);
      return {2'b00, idx, 2'b00};
   endfunction : ad
   function automatic logic near(input logic [15:0] got, input int cyc, input int per);
      return (int'(got) >= cyc / per - 1) && (int'(got) <= cyc / per + 1);
   endfunction : near
   task automatic pulse(input logic trig);
      @(posedge aclk);
      if (trig) trig_req <= 1'b1;
      else evt_req <= 1'b1;
      @(posedge aclk);
      trig_req <= 1'b0;
      evt_req <= 1'b0;
      repeat (12) @(posedge aclk);
   endtask : pulse
   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      // every register reads zero after reset
      for (i = 0; i < 8; i++) begin
         rdr(ad(regs[i]));
         `CHK("reset value", 32'h0, rd)
      end
      rdr(12'h800);
      `CHK("unmapped read resp", RESP_SLVERR, rsp)
      wr(ad(8'hff), 8'h12);
      `CHK("unmapped write resp", RESP_SLVERR, rsp)
      // overflow with reload, fast prescale so it comes within 64 clocks
      hi = 8'($random(seed));
      wr(ad(IDX_CLK_SPEED), 8'h20);
      wr(ad(IDX_RCAP_HI), hi);
      wr(ad(IDX_CNT_LO), 8'hf0);
      wr(ad(IDX_CNT_HI), 8'hff);
      wr(ad(IDX_CTRL), 8'h04);
      for (n = 0; n < 300 && timer_irq !== 1'b1; n++) @(posedge aclk);
      give_up(n, 300);
      rdr(ad(IDX_CNT_HI));
      `CHK("reloaded high byte", {24'h0, hi}, rd)
      rdr(ad(IDX_CTRL));
      `CHK("overflow flag", 32'h84, rd)
      rdr(ad(IDX_INT_STAT));
      `CHK("int status", 32'h1, rd)
      `CHK("masked irq", 1'b0, irq)
      wr(ad(IDX_INT_MASK), 8'h01);
      repeat (2) @(posedge aclk);
      `CHK("unmasked irq", 1'b1, irq)
      wr(ad(IDX_INT_STAT), 8'h01);
      repeat (2) @(posedge aclk);
      `CHK("cleared irq", 1'b0, irq)
      wr(ad(IDX_CTRL), 8'h00);
      repeat (2) @(posedge aclk);
      `CHK("flag cleared request", 1'b0, timer_irq)
      rdr(ad(IDX_CNT_LO));
      lo = rd[7:0];
      repeat (40) @(posedge aclk);
      rdr(ad(IDX_CNT_LO));
      `CHK("halted count", {24'h0, lo}, rd)
      // capture while halted so the count is known
      {hi, lo} = 16'($random(seed));
      wr(ad(IDX_CNT_LO), lo);
      wr(ad(IDX_CNT_HI), hi);
      wr(ad(IDX_CTRL), 8'h09);
      pulse(1'b1);
      rdr(ad(IDX_RCAP_LO));
      `CHK("captured low", {24'h0, lo}, rd)
      rdr(ad(IDX_RCAP_HI));
      `CHK("captured high", {24'h0, hi}, rd)
      rdr(ad(IDX_CTRL));
      `CHK("external flag", 32'h49, rd)
      `CHK("external request", 1'b1, timer_irq)
      // trigger without enable does nothing
      wr(ad(IDX_CTRL), 8'h01);
      wr(ad(IDX_CNT_HI), ~hi);
      pulse(1'b1);
      rdr(ad(IDX_RCAP_HI));
      `CHK("ignored trigger", {24'h0, hi}, rd)
      rdr(ad(IDX_CTRL));
      `CHK("no external flag", 32'h01, rd)
      // trigger reload
      {hi2, lo2} = 16'($random(seed));
      wr(ad(IDX_RCAP_LO), lo2);
      wr(ad(IDX_RCAP_HI), hi2);
      wr(ad(IDX_CTRL), 8'h08);
      pulse(1'b1);
      rdr(ad(IDX_CNT_LO));
      `CHK("trigger reload low", {24'h0, lo2}, rd)
      rdr(ad(IDX_CNT_HI));
      `CHK("trigger reload high", {24'h0, hi2}, rd)
      // a write without byte lane 0 leaves the register alone
      wstrb <= 4'he;
      wr(ad(IDX_RCAP_LO), ~lo2);
      wstrb <= 4'hf;
      `CHK("no lane write resp", RESP_OKAY, rsp)
      rdr(ad(IDX_RCAP_LO));
      `CHK("no lane write", {24'h0, lo2}, rd)
      // software-set flags request an interrupt
      for (i = 0; i < 2; i++) begin
         wr(ad(IDX_CTRL), i ? 8'h40 : 8'h80);
         repeat (2) @(posedge aclk);
         `CHK("software request", 1'b1, timer_irq)
         wr(ad(IDX_CTRL), 8'h00);
         repeat (2) @(posedge aclk);
         `CHK("request gone", 1'b0, timer_irq)
      end
      // event counting
      wr(ad(IDX_CNT_LO), 8'h00);
      wr(ad(IDX_CNT_HI), 8'h00);
      wr(ad(IDX_CTRL), 8'h06);
      n = 1 + ($unsigned($random(seed)) % 6);
      repeat (n) pulse(1'b0);
      wr(ad(IDX_CTRL), 8'h00);
      rdr(ad(IDX_CNT_LO));
      `CHK("event count", n, rd)
      // baud modes: own overflow every 16 ticks of 2 clocks, else the other timer
      wr(ad(IDX_RCAP_LO), 8'hf0);
      wr(ad(IDX_RCAP_HI), 8'hff);
      // start at the reload value so the first own overflow comes within 32 clocks, like the rest
      wr(ad(IDX_CNT_LO), 8'hf0);
      wr(ad(IDX_CNT_HI), 8'hff);
      for (i = 0; i < 3; i++) begin
         wr(ad(IDX_CTRL), modes[i]);
         repeat (40) @(posedge aclk);
         clr_counts <= 1'b1;
         @(posedge aclk);
         clr_counts <= 1'b0;
         repeat (640) @(posedge aclk);
         `CHK("rx ticks", 1'b1, near(rx_count, 640, modes[i][5] ? 32 : PER))
         `CHK("tx ticks", 1'b1, near(tx_count, 640, modes[i][4] ? 32 : PER))
         rdr(ad(IDX_CTRL));
         `CHK("no flag in baud", {24'h0, modes[i]}, rd)
      end
      wrap_up();
   end
endmodule : test_timer_two_capture_reload_baud
